/* hdl/dac_digital_gain_sidetone.sv */
/*
  Stereo DAC digital front end: channel enables, double-buffered
  8-bit volume, sidetone mix with 4-bit gain, interpolation to the
  modulators. Register port: write strobe, read strobe, read data in
  the next cycle only. Microphone inputs are the high-pass filtered taps.
*/
`timescale 1ns/10ps
`include "dac_gain_defines.svh"

module dac_digital_gain_sidetone #(
  parameter int OSR_LOG2 = `OSR_LOG2_DEF
) (
  input  wire logic                clk,
  input  wire logic                sys_rst,
  input  wire logic [`ADDR_W-1:0]  reg_addr,
  input  wire logic [`DATA_W-1:0]  reg_wdata,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  output logic [`DATA_W-1:0]       reg_rdata,
  input  dac_gain_pkg::sample_t    iface_rx_left,
  input  dac_gain_pkg::sample_t    iface_rx_right,
  input  dac_gain_pkg::sample_t    mic_hpf_left,
  input  dac_gain_pkg::sample_t    mic_hpf_right,
  output dac_gain_pkg::sample_t    mod_left,
  output dac_gain_pkg::sample_t    mod_right
);
  localparam int SW = `SAMPLE_W;

  // Saturating add of two samples
  // Clips at full scale: a wrapped sum would flip the sign and
  // turn a loud peak into a full-scale click of the other polarity.
  function automatic logic signed [SW-1:0] sat_add(
    input logic signed [SW-1:0] a,
    input logic signed [SW-1:0] b
  );
    logic signed [SW:0] s;
    s = (SW+1)'(a) + (SW+1)'(b);
    if (s[SW] != s[SW-1]) begin
      sat_add = s[SW] ? {1'b1, {(SW-1){1'b0}}} : {1'b0, {(SW-1){1'b1}}};
    end else begin
      sat_add = s[SW-1:0];
    end
  endfunction

  // Gain of 2**(-k*0.375/6) for the fine step k, Q1.15
  // Sixteen fine steps make one halving, so the coarse part of an
  // attenuation is a plain shift and only this small table is needed.
  function automatic logic [16:0] mant_lut(input logic [3:0] k);
    case (k)
      4'h0:    mant_lut = 17'h08000;
      4'h1:    mant_lut = 17'h07a93;
      4'h2:    mant_lut = 17'h07561;
      4'h3:    mant_lut = 17'h07067;
      4'h4:    mant_lut = 17'h06ba3;
      4'h5:    mant_lut = 17'h06713;
      4'h6:    mant_lut = 17'h062b4;
      4'h7:    mant_lut = 17'h05e84;
      4'h8:    mant_lut = 17'h05a82;
      4'h9:    mant_lut = 17'h056ac;
      4'ha:    mant_lut = 17'h052ff;
      4'hb:    mant_lut = 17'h04f7b;
      4'hc:    mant_lut = 17'h04c1c;
      4'hd:    mant_lut = 17'h048e2;
      4'he:    mant_lut = 17'h045cb;
      default: mant_lut = 17'h042d6;
    endcase
  endfunction

  // Attenuate by steps of 0.375 dB; 16 steps make one halving
  // The product keeps all bits until the shift; the result is then
  // truncated toward minus infinity, so small negatives end at -1.
  // Mute forces zero rather than relying on the deepest shift.
  function automatic logic signed [SW-1:0] apply_gain(
    input logic signed [SW-1:0] x,
    input logic [7:0]           steps,
    input logic                 mute
  );
    logic signed [17:0]    m;
    logic signed [SW+17:0] prod;
    logic signed [SW+17:0] shifted;
    m       = {1'b0, mant_lut(steps[3:0])};
    prod    = x * m;
    shifted = prod >>> (`MANT_FRAC + steps[7:4]);
    apply_gain = mute ? '0 : shifted[SW-1:0];
  endfunction

  // Volume code to attenuation steps
  // Codes from C0h up are all unity; below that each code is one
  // fine step, so the whole range needs no table of its own.
  function automatic logic [7:0] vol_steps(input logic [7:0] code);
    if (code >= `VOL_FULL) begin
      vol_steps = 8'h00;
    end else begin
      vol_steps = `VOL_FULL - code;
    end
  endfunction

  // Sidetone code to attenuation steps; 3 dB is 8 steps
  // Codes 12 to 15 saturate at unity, so one attenuator serves both
  // the sidetone and the channel volume.
  function automatic logic [7:0] st_steps(input logic [3:0] g);
    if (g >= `ST_GAIN_FULL) begin
      st_steps = 8'h00;
    end else begin
      st_steps = {1'b0, 4'(`ST_GAIN_FULL - g), 3'h0};
    end
  endfunction

  // Register state
  // Holding codes are what software last wrote; active codes are what
  // the datapath uses. They only meet on a commit.
  logic [7:0]                   left_gain_code_ff,  nxt_left_gain_code;
  logic [7:0]                   right_gain_code_ff, nxt_right_gain_code;
  logic [7:0]                   left_active_ff,     nxt_left_active;
  logic [7:0]                   right_active_ff,    nxt_right_active;
  logic                         left_conv_on_ff,    nxt_left_conv_on;
  logic                         right_conv_on_ff,   nxt_right_conv_on;
  dac_gain_pkg::sidetone_cfg_t  left_st_ff,         nxt_left_st;
  dac_gain_pkg::sidetone_cfg_t  right_st_ff,        nxt_right_st;
  logic [`DATA_W-1:0]           rdata_ff,           nxt_rdata;
  logic                         wr_left_vol;
  logic                         wr_right_vol;
  logic                         gain_commit;

  // Register writes and the simultaneous volume update
  // A commit also takes the code written in the same cycle, so one
  // write with the update bit set changes its own channel at once.
  // Both active codes load on the same edge, keeping the pair in step.
  always_comb begin
    wr_left_vol  = reg_wr && (reg_addr == `OFS_LEFT_VOL);
    wr_right_vol = reg_wr && (reg_addr == `OFS_RIGHT_VOL);
    gain_commit  = (wr_left_vol || wr_right_vol)
                   && reg_wdata[`BIT_COMMIT];
    nxt_left_gain_code  = left_gain_code_ff;
    nxt_right_gain_code = right_gain_code_ff;
    if (wr_left_vol) begin
      nxt_left_gain_code = reg_wdata[`VOL_MSB:`VOL_LSB];
    end
    if (wr_right_vol) begin
      nxt_right_gain_code = reg_wdata[`VOL_MSB:`VOL_LSB];
    end
    nxt_left_active  = left_active_ff;
    nxt_right_active = right_active_ff;
    if (gain_commit) begin
      nxt_left_active  = nxt_left_gain_code;
      nxt_right_active = nxt_right_gain_code;
    end
    nxt_left_conv_on  = left_conv_on_ff;
    nxt_right_conv_on = right_conv_on_ff;
    if (reg_wr && (reg_addr == `OFS_POWER)) begin
      nxt_left_conv_on  = reg_wdata[`BIT_LEFT_ON];
      nxt_right_conv_on = reg_wdata[`BIT_RIGHT_ON];
    end
    nxt_left_st  = left_st_ff;
    nxt_right_st = right_st_ff;
    if (reg_wr && (reg_addr == `OFS_SIDETONE)) begin
      nxt_left_st.gain  = reg_wdata[`LST_GAIN_MSB:`LST_GAIN_LSB];
      nxt_right_st.gain = reg_wdata[`RST_GAIN_MSB:`RST_GAIN_LSB];
      nxt_left_st.src   =
        dac_gain_pkg::st_src_t'(reg_wdata[`LST_SRC_MSB:`LST_SRC_LSB]);
      nxt_right_st.src  =
        dac_gain_pkg::st_src_t'(reg_wdata[`RST_SRC_MSB:`RST_SRC_LSB]);
    end
  end

  // Read data, valid only in the cycle after the strobe
  // Cleared whenever no read is pending, so a stale answer never
  // lingers on the bus. The update bit always reads zero.
  always_comb begin
    nxt_rdata = '0;
    if (reg_rd) begin
      case (reg_addr)
        `OFS_POWER: begin
          nxt_rdata[`BIT_LEFT_ON]  = left_conv_on_ff;
          nxt_rdata[`BIT_RIGHT_ON] = right_conv_on_ff;
        end
        `OFS_LEFT_VOL: begin
          nxt_rdata[`VOL_MSB:`VOL_LSB] = left_gain_code_ff;
        end
        `OFS_RIGHT_VOL: begin
          nxt_rdata[`VOL_MSB:`VOL_LSB] = right_gain_code_ff;
        end
        `OFS_SIDETONE: begin
          nxt_rdata[`LST_GAIN_MSB:`LST_GAIN_LSB] = left_st_ff.gain;
          nxt_rdata[`RST_GAIN_MSB:`RST_GAIN_LSB] = right_st_ff.gain;
          nxt_rdata[`LST_SRC_MSB:`LST_SRC_LSB]   = left_st_ff.src;
          nxt_rdata[`RST_SRC_MSB:`RST_SRC_LSB]   = right_st_ff.src;
        end
        `OFS_ACTIVE: begin
          nxt_rdata = {right_active_ff, left_active_ff};
        end
        default: begin
          nxt_rdata = '0;
        end
      endcase
    end
  end

  // Register flops; reset sets unity volume and both lanes off
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      left_gain_code_ff  <= `VOL_RST;
      right_gain_code_ff <= `VOL_RST;
      left_active_ff     <= `VOL_RST;
      right_active_ff    <= `VOL_RST;
      left_conv_on_ff    <= 1'b0;
      right_conv_on_ff   <= 1'b0;
      left_st_ff         <= {`ST_GAIN_RST, dac_gain_pkg::ST_NONE};
      right_st_ff        <= {`ST_GAIN_RST, dac_gain_pkg::ST_NONE};
      rdata_ff           <= '0;
    end else begin
      left_gain_code_ff  <= nxt_left_gain_code;
      right_gain_code_ff <= nxt_right_gain_code;
      left_active_ff     <= nxt_left_active;
      right_active_ff    <= nxt_right_active;
      left_conv_on_ff    <= nxt_left_conv_on;
      right_conv_on_ff   <= nxt_right_conv_on;
      left_st_ff         <= nxt_left_st;
      right_st_ff        <= nxt_right_st;
      rdata_ff           <= nxt_rdata;
    end
  end

  // Read data straight from its flop
  assign reg_rdata = rdata_ff;

  // Latest filtered microphone samples for the sidetone taps
  // The taps run at their own rate; holding the last one lets each
  // receive sample mix the most recent tap without any buffer
  // between the two rates.
  logic signed [SW-1:0] mic_hold_ff [2];
  logic signed [SW-1:0] nxt_mic_hold [2];

  always_comb begin
    nxt_mic_hold[0] = mic_hold_ff[0];
    nxt_mic_hold[1] = mic_hold_ff[1];
    if (mic_hpf_left.valid) begin
      nxt_mic_hold[0] = mic_hpf_left.data;
    end
    if (mic_hpf_right.valid) begin
      nxt_mic_hold[1] = mic_hpf_right.data;
    end
  end

  // Tap holds, silent after reset
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mic_hold_ff[0] <= '0;
      mic_hold_ff[1] <= '0;
    end else begin
      mic_hold_ff[0] <= nxt_mic_hold[0];
      mic_hold_ff[1] <= nxt_mic_hold[1];
    end
  end

  // Per-channel views of the settings, index 0 left, 1 right
  // These only rename, so the lane loop below can index a channel.
  dac_gain_pkg::sample_t        rx_smp   [2];
  logic [7:0]                   vol_code [2];
  logic                         conv_on  [2];
  dac_gain_pkg::sidetone_cfg_t  st_cfg   [2];
  dac_gain_pkg::sample_t        mod_out  [2];

  assign rx_smp[0]   = iface_rx_left;
  assign rx_smp[1]   = iface_rx_right;
  assign vol_code[0] = left_active_ff;
  assign vol_code[1] = right_active_ff;
  assign conv_on[0]  = left_conv_on_ff;
  assign conv_on[1]  = right_conv_on_ff;
  assign st_cfg[0]   = left_st_ff;
  assign st_cfg[1]   = right_st_ff;

  // Mix, volume and interpolation, one lane per channel
  // Volume comes after the mix, so it scales the sidetone too and a
  // muted channel is silent. A disabled lane pulses but carries zeros.
  for (genvar ch = 0; ch < 2; ch++) begin : g_chan
    logic signed [SW-1:0]   st_pick;
    logic signed [SW-1:0]   st_scaled;
    dac_gain_pkg::sample_t  mix_ff, nxt_mix;
    dac_gain_pkg::sample_t  vol_ff, nxt_vol;

    // Sidetone pick and scale, mix, then channel volume
    always_comb begin
      case (st_cfg[ch].src)
        dac_gain_pkg::ST_LEFT_MIC: begin
          st_pick = mic_hold_ff[0];
        end
        dac_gain_pkg::ST_RIGHT_MIC: begin
          st_pick = mic_hold_ff[1];
        end
        default: begin
          st_pick = '0;
        end
      endcase
      st_scaled     = apply_gain(st_pick, st_steps(st_cfg[ch].gain), 1'b0);
      nxt_mix.valid = rx_smp[ch].valid;
      nxt_mix.data  = mix_ff.data;
      if (rx_smp[ch].valid) begin
        nxt_mix.data = sat_add(rx_smp[ch].data, st_scaled);
      end
      nxt_vol.valid = mix_ff.valid;
      nxt_vol.data  = vol_ff.data;
      if (mix_ff.valid) begin
        if (conv_on[ch]) begin
          nxt_vol.data = apply_gain(mix_ff.data, vol_steps(vol_code[ch]),
                                    vol_code[ch] == `VOL_MUTE);
        end else begin
          nxt_vol.data = '0;
        end
      end
    end

    // Mix and volume stages
    always_ff @(posedge clk) begin
      if (sys_rst) begin
        mix_ff <= '0;
        vol_ff <= '0;
      end else begin
        mix_ff <= nxt_mix;
        vol_ff <= nxt_vol;
      end
    end

    // Oversampled stream to the modulator
    // The interpolator clears its state while the lane is off, so a
    // re-enabled lane ramps from silence, not from an old level.
    oversample_interp #(
      .SW       (SW),
      .OSR_LOG2 (OSR_LOG2)
    ) u_interp (
      .clk      (clk),
      .sys_rst  (sys_rst),
      .conv_on  (conv_on[ch]),
      .in_smp   (vol_ff),
      .out_smp  (mod_out[ch])
    );
  end

  // Lane outputs straight from the interpolator flops
  assign mod_left  = mod_out[0];
  assign mod_right = mod_out[1];

endmodule

/* hdl/oversample_interp.sv */
/*
  Linear interpolator: each input sample starts 2**OSR_LOG2 output
  samples, one per clock, stepping from the last target to the new one.
  Assumes input samples are at least 2**OSR_LOG2+1 clocks apart.
*/
`timescale 1ns/10ps
`include "dac_gain_defines.svh"

module oversample_interp #(
  parameter int SW       = `SAMPLE_W,
  parameter int OSR_LOG2 = `OSR_LOG2_DEF
) (
  input  wire logic                clk,
  input  wire logic                sys_rst,
  input  wire logic                conv_on,
  input  dac_gain_pkg::sample_t    in_smp,
  output dac_gain_pkg::sample_t    out_smp
);
  localparam int AW = SW + OSR_LOG2;

  logic signed [AW-1:0]   acc_ff,  nxt_acc;
  logic signed [SW:0]     step_ff, nxt_step;
  logic signed [SW-1:0]   tgt_ff,  nxt_tgt;
  logic [OSR_LOG2:0]      left_ff, nxt_left;
  dac_gain_pkg::sample_t  out_ff,  nxt_out;

  // Step computation and tick countdown
  always_comb begin
    nxt_acc       = acc_ff;
    nxt_step      = step_ff;
    nxt_tgt       = tgt_ff;
    nxt_left      = left_ff;
    nxt_out       = out_ff;
    nxt_out.valid = 1'b0;
    if (in_smp.valid) begin
      nxt_step = (SW+1)'(in_smp.data) - (SW+1)'(tgt_ff);
      nxt_acc  = {tgt_ff, {OSR_LOG2{1'b0}}};
      nxt_tgt  = in_smp.data;
      nxt_left = (OSR_LOG2+1)'(1 << OSR_LOG2);
    end else if (left_ff != '0) begin
      nxt_acc       = acc_ff + AW'(step_ff);
      nxt_left      = left_ff - 1'b1;
      nxt_out.valid = 1'b1;
      nxt_out.data  = nxt_acc[AW-1:OSR_LOG2];
    end
    if (!conv_on) begin
      nxt_acc      = '0;
      nxt_step     = '0;
      nxt_tgt      = '0;
      nxt_out.data = '0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      acc_ff  <= '0;
      step_ff <= '0;
      tgt_ff  <= '0;
      left_ff <= '0;
      out_ff  <= '0;
    end else begin
      acc_ff  <= nxt_acc;
      step_ff <= nxt_step;
      tgt_ff  <= nxt_tgt;
      left_ff <= nxt_left;
      out_ff  <= nxt_out;
    end
  end

  assign out_smp = out_ff;

endmodule

/* inc/dac_gain_defines.svh */
/*
  Constants of the DAC digital gain and sidetone front end: offsets,
  field positions, reset values and gain decode figures.
  Assumes an 8-bit register address and 16-bit register data.
*/
// Summary of operation
// - Sidetone gain: -36 dB plus 3 dB/step, 0 dB top
// - Channel input is interface data plus sidetone
// - Mixed audio interpolated at 24-bit precision
// - Enable bits 3 left, 2 right, reset 0
// - Volume spans -71.625 to 0 dB, 0.375 steps
// - Volume code 00h mutes, C0h-FFh 0 dB, reset C0h
// - Volume write without update only loads holding register
// - Update copies both held codes to active together
// - Update bit 8 in either volume register
// - Sidetone source: none, left mic, right mic, reserved
// - Sidetone taken after microphone high-pass filter
`ifndef DAC_GAIN_DEFINES_SVH
`define DAC_GAIN_DEFINES_SVH

`define ADDR_W         8
`define DATA_W         16
`define SAMPLE_W       24
`define OSR_LOG2_DEF   3

`define OFS_POWER      8'h12
`define OFS_LEFT_VOL   8'h1e
`define OFS_RIGHT_VOL  8'h1f
`define OFS_SIDETONE   8'h20
`define OFS_ACTIVE     8'h21

`define BIT_LEFT_ON    3
`define BIT_RIGHT_ON   2
`define BIT_COMMIT     8
`define VOL_MSB        7
`define VOL_LSB        0
`define LST_GAIN_MSB   11
`define LST_GAIN_LSB   8
`define RST_GAIN_MSB   7
`define RST_GAIN_LSB   4
`define LST_SRC_MSB    3
`define LST_SRC_LSB    2
`define RST_SRC_MSB    1
`define RST_SRC_LSB    0

`define VOL_RST        8'hc0
`define VOL_MUTE       8'h00
`define VOL_FULL       8'hc0
`define ST_GAIN_RST    4'h0
`define ST_GAIN_FULL   4'hc
`define MANT_FRAC      15

`endif

/* inc/dac_gain_pkg.sv */
/*
  Types shared by the DAC gain front end and its interpolator.
  Assumes the constants header is on the include path.
*/
`include "dac_gain_defines.svh"

package dac_gain_pkg;

  // One audio sample with its strobe
  typedef struct packed {
    logic                        valid;
    logic signed [`SAMPLE_W-1:0] data;
  } sample_t;

  // Sidetone source field encoding
  typedef enum logic [1:0] {
    ST_NONE      = 2'h0,
    ST_LEFT_MIC  = 2'h1,
    ST_RIGHT_MIC = 2'h2,
    ST_RESERVED  = 2'h3
  } st_src_t;

  // Per-channel sidetone settings
  typedef struct packed {
    logic [3:0] gain;
    st_src_t    src;
  } sidetone_cfg_t;

endpackage

/* tb/audio_feed.sv */
/*
  Far-side model: interface receive samples and filtered microphone taps.
  Assumes callers space receive samples beyond one output burst.
*/
`timescale 1ns/10ps

module audio_feed (
  input  wire logic             clk,
  output dac_gain_pkg::sample_t rx_left,
  output dac_gain_pkg::sample_t rx_right,
  output dac_gain_pkg::sample_t mic_left,
  output dac_gain_pkg::sample_t mic_right
);
  // Idle lanes carry no strobe and junk data
  initial begin
    rx_left   = '{1'b0, 24'h5a5a5a};
    rx_right  = '{1'b0, 24'ha5a5a5};
    mic_left  = '{1'b0, 24'h3c3c3c};
    mic_right = '{1'b0, 24'hc3c3c3};
  end

  // One receive sample on both lanes, then inverse on the lines
  task automatic play(input logic [23:0] l, input logic [23:0] r);
    @(posedge clk);
    rx_left  <= '{1'b1, l};
    rx_right <= '{1'b1, r};
    @(posedge clk);
    rx_left  <= '{1'b0, ~l};
    rx_right <= '{1'b0, ~r};
  endtask

  // High-pass filtered taps, held by the device after the strobe
  task automatic tap(input logic [23:0] l, input logic [23:0] r);
    @(posedge clk);
    mic_left  <= '{1'b1, l};
    mic_right <= '{1'b1, r};
    @(posedge clk);
    mic_left  <= '{1'b0, ~l};
    mic_right <= '{1'b0, ~r};
  endtask
endmodule

/* tb/dac_digital_gain_sidetone_bench.sv */
/*
  Self-checking bench for the DAC gain front end: registers, sidetone
  mix with saturation, mute, volume hold and commit, channel enables.
  Assumes unity gain for volume codes from C0h and sidetone codes from 12,
  and 6 dB per halving: sidetone code 8 and volume code 80h are shifts.
*/
`timescale 1ns/10ps

module dac_digital_gain_sidetone_bench;
  localparam int OSR = 1;
  localparam int NB  = 1 << OSR;
  logic                  clk, sys_rst, reg_wr, reg_rd, rd_pend;
  logic [7:0]            reg_addr, act[2];
  logic [15:0]           reg_wdata, reg_rdata, rq[$];
  logic [23:0]           aq[2][$], mic[2];
  logic [1:0]            en, src[2];
  logic [31:0]           seed;
  int                    error_cnt, checked, cnt[2];
  dac_gain_pkg::sample_t rx_l, rx_r, mic_l, mic_r, mod_l, mod_r;

  dac_digital_gain_sidetone #(.OSR_LOG2(OSR)) i_dac_digital_gain_sidetone (
    .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .iface_rx_left(rx_l), .iface_rx_right(rx_r),
    .mic_hpf_left(mic_l), .mic_hpf_right(mic_r), .mod_left(mod_l), .mod_right(mod_r)
  );
  audio_feed i_audio_feed (
    .clk(clk), .rx_left(rx_l), .rx_right(rx_r), .mic_left(mic_l), .mic_right(mic_r)
  );

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [23:0] sat(input logic signed [24:0] s);
    if (s > 25'sh07fffff) return 24'h7fffff;
    if (s < -25'sh0800000) return 24'h800000;
    return s[23:0];
  endfunction

  task automatic cmp(input logic [23:0] got, input logic [23:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_reg(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // Register bus cycles
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    rq.push_back(e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
  endtask

  // New held microphone taps
  task automatic new_mic();
    mic[0] = 24'(rnd());
    mic[1] = 24'(rnd());
    i_audio_feed.tap(mic[0], mic[1]);
  endtask
  // Random receive samples with their expected channel outputs
  task automatic send();
    logic [23:0] d[2], s;
    logic signed [23:0] y;
    for (int i = 0; i < 2; i++) begin
      d[i] = 24'(rnd());
      s = (src[i] == 2'h1) ? mic[0] : (src[i] == 2'h2) ? mic[1] : 24'h0;
      s = $signed(s) >>> ((i == 0) ? 2 : 0);
      y = sat($signed({d[i][23], d[i]}) + $signed({s[23], s}));
      y = y >>> ((act[i] < 8'hc0) ? (8'hc0 - act[i]) >> 4 : 0);
      aq[i].push_back((en[i] && act[i] != 8'h00) ? y : 24'h0);
    end
    i_audio_feed.play(d[0], d[1]);
    repeat (8) @(posedge clk);
  endtask

  // Clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Watchdog
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    stop_test();
  end
  // Read answers and the last sample of each output burst
  always @(negedge clk) begin
    if (rd_pend) cmp_reg(reg_rdata, rq.pop_front());
    rd_pend = reg_rd;
    for (int i = 0; i < 2; i++) begin
      if ((i == 0) ? mod_l.valid : mod_r.valid) cnt[i]++;
      if (cnt[i] == NB) begin
        cnt[i] = 0;
        cmp((i == 0) ? mod_l.data : mod_r.data, aq[i].pop_front());
      end
    end
  end

  // Main sequence
  initial begin
    sys_rst   = 1'b1;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 16'h0000;
    rd_pend   = 1'b0;
    seed      = 32'hf6a700b7;
    en        = 2'h0;
    act       = '{8'hc0, 8'hc0};
    src       = '{2'h0, 2'h0};
    mic       = '{24'h0, 24'h0};
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    rd(8'h12, 16'h0000);
    rd(8'h1e, 16'h00c0);
    rd(8'h1f, 16'h00c0);
    rd(8'h20, 16'h0000);
    rd(8'h21, 16'hc0c0);
    rd(8'h55, 16'h0000);
    send();
    en = 2'h3;
    wr(8'h12, 16'h000c);
    for (int k = 0; k < 4; k++) begin
      src[0] = 2'(k);
      src[1] = 2'(3 - k);
      wr(8'h20, {4'h0, 4'h8, 4'hf, src[0], src[1]});
      rd(8'h20, {4'h0, 4'h8, 4'hf, src[0], src[1]});
      new_mic();
      repeat (3) send();
    end
    wr(8'h1e, 16'h0000);
    rd(8'h21, 16'hc0c0);
    send();
    wr(8'h1f, 16'h0100);
    act = '{8'h00, 8'h00};
    rd(8'h21, 16'h0000);
    rd(8'h1f, 16'h0000);
    send();
    wr(8'h1e, 16'h0180);
    act[0] = 8'h80;
    rd(8'h21, 16'h0080);
    send();
    wr(8'h1f, 16'h01ff);
    act[1] = 8'hff;
    en = 2'h2;
    wr(8'h12, 16'h0004);
    repeat (2) send();
    rd(8'h1e, 16'h0080);
    for (int w = 0; w < 100 && aq[0].size() + aq[1].size() + rq.size() != 0; w++) begin
      @(posedge clk);
    end
    if (aq[0].size() + aq[1].size() + rq.size() != 0) error_cnt++;
    stop_test();
  end
endmodule

/* tb/dac_gain_props.sv */
/*
  Checker for the DAC gain front end: register readback and output timing.
  Assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/10ps
`include "dac_gain_defines.svh"

module dac_gain_props #(
  parameter int OSR_LOG2 = `OSR_LOG2_DEF
) (
  input wire logic               clk,
  input wire logic               sys_rst,
  input wire logic [`ADDR_W-1:0] reg_addr,
  input wire logic [`DATA_W-1:0] reg_wdata,
  input wire logic               reg_wr,
  input wire logic               reg_rd,
  input wire logic [`DATA_W-1:0] reg_rdata,
  input dac_gain_pkg::sample_t   iface_rx_left,
  input dac_gain_pkg::sample_t   iface_rx_right,
  input dac_gain_pkg::sample_t   mic_hpf_left,
  input dac_gain_pkg::sample_t   mic_hpf_right,
  input dac_gain_pkg::sample_t   mod_left,
  input dac_gain_pkg::sample_t   mod_right
);
  localparam int NB = 1 << OSR_LOG2;
  logic [1:0]  en_ff, nxt_en;
  logic [7:0]  hl_ff, nxt_hl, hr_ff, nxt_hr, cnt_ff, nxt_cnt;
  logic [15:0] act_ff, nxt_act;
  logic [11:0] st_ff, nxt_st;
  logic        wr_vol, mapped;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  // Decode of volume writes and mapped reads
  assign wr_vol = reg_wr && (reg_addr inside {`OFS_LEFT_VOL, `OFS_RIGHT_VOL});
  assign mapped = reg_addr inside {`OFS_POWER, `OFS_LEFT_VOL, `OFS_RIGHT_VOL, `OFS_SIDETONE,
                                   `OFS_ACTIVE};

  // Shadow register state and output burst countdown
  always_comb begin
    nxt_en  = en_ff;
    nxt_hl  = hl_ff;
    nxt_hr  = hr_ff;
    nxt_act = act_ff;
    nxt_st  = st_ff;
    nxt_cnt = (cnt_ff != 8'h00) ? cnt_ff - 8'h01 : 8'h00;
    if (iface_rx_left.valid) nxt_cnt = 8'(NB + 3);
    if (reg_wr && reg_addr == `OFS_POWER) begin
      nxt_en = {reg_wdata[`BIT_LEFT_ON], reg_wdata[`BIT_RIGHT_ON]};
    end
    if (reg_wr && reg_addr == `OFS_LEFT_VOL) nxt_hl = reg_wdata[7:0];
    if (reg_wr && reg_addr == `OFS_RIGHT_VOL) nxt_hr = reg_wdata[7:0];
    if (reg_wr && reg_addr == `OFS_SIDETONE) nxt_st = reg_wdata[11:0];
    if (wr_vol && reg_wdata[`BIT_COMMIT]) nxt_act = {nxt_hr, nxt_hl};
    if (sys_rst) begin
      nxt_en  = 2'h0;
      nxt_hl  = `VOL_RST;
      nxt_hr  = `VOL_RST;
      nxt_act = {`VOL_RST, `VOL_RST};
      nxt_st  = 12'h000;
      nxt_cnt = 8'h00;
    end
  end
  always_ff @(posedge clk) begin
    en_ff  <= nxt_en;
    hl_ff  <= nxt_hl;
    hr_ff  <= nxt_hr;
    act_ff <= nxt_act;
    st_ff  <= nxt_st;
    cnt_ff <= nxt_cnt;
  end

  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data not zero outside answer cycle");
  power_read_a: assert property ($past(reg_rd) && $past(reg_addr) == `OFS_POWER |->
    reg_rdata == {12'h000, $past(en_ff), 2'h0}) else $error("enable readback wrong");
  left_hold_a: assert property ($past(reg_rd) && $past(reg_addr) == `OFS_LEFT_VOL |->
    reg_rdata == {8'h00, $past(hl_ff)}) else $error("left holding code wrong");
  right_hold_a: assert property ($past(reg_rd) && $past(reg_addr) == `OFS_RIGHT_VOL |->
    reg_rdata == {8'h00, $past(hr_ff)}) else $error("right holding code wrong");
  active_pair_a: assert property ($past(reg_rd) && $past(reg_addr) == `OFS_ACTIVE |->
    reg_rdata == $past(act_ff)) else $error("active codes wrong");
  sidetone_read_a: assert property ($past(reg_rd) && $past(reg_addr) == `OFS_SIDETONE |->
    reg_rdata == {4'h0, $past(st_ff)}) else $error("sidetone readback wrong");
  unmapped_read_a: assert property ($past(reg_rd) && !$past(mapped) |->
    reg_rdata == 16'h0000) else $error("unmapped read not zero");
  out_start_a: assert property (iface_rx_right.valid |-> ##4 mod_right.valid)
    else $error("right output burst late");
  out_window_a: assert property (mod_left.valid |->
    cnt_ff != 8'h00 && cnt_ff <= 8'(NB)) else $error("left output outside burst");

  commit_c: cover property (reg_wr && reg_wdata[`BIT_COMMIT]);
  status_c: cover property (reg_rd && reg_addr == `OFS_ACTIVE);
  burst_c: cover property (mod_left.valid ##1 mod_left.valid);
endmodule

bind dac_digital_gain_sidetone dac_gain_props #(.OSR_LOG2(OSR_LOG2)) i_dac_gain_props (
  .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .iface_rx_left(iface_rx_left),
  .iface_rx_right(iface_rx_right), .mic_hpf_left(mic_hpf_left),
  .mic_hpf_right(mic_hpf_right), .mod_left(mod_left), .mod_right(mod_right)
);
